/* File: design/repeater_id_field_pkg.sv */
package repeater_id_field_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register offsets on the serial management bus
  localparam logic [4:0] REG_STATUS = 5'h05; // identity and status word
  localparam logic [4:0] REG_HUB_LOW = 5'h06; // first sixteen eeprom bits
  localparam logic [4:0] REG_HUB_HIGH = 5'h07; // next sixteen eeprom bits

  ////////////////////////////////////////////////////////////////////////
  // field positions in the identity and status word
  localparam int T4_BIT = 12; // t4 detected flag
  localparam int PORT_LSB = 8; // receiving port number, four bits
  localparam int EEPROM_READ_DONE_BIT = 7; // eeprom read finished
  localparam int RID_ERR_BIT = 5; // repeater id error flag
  localparam int ID_LSB = 0; // repeater id, five bits
  localparam logic [15:0] RESERVED_MASK = 16'he040; // bits 15..13 and 6

  ////////////////////////////////////////////////////////////////////////
  // reset values and special codes
  localparam logic [4:0] ID_RST = 5'h00; // id before the straps are taken
  localparam logic [4:0] ID_ILLEGAL = 5'h1f; // all-ones vector code
  localparam logic [3:0] PORT_RST = 4'h0; // port number after reset
  localparam logic [31:0] HUB_RST = 32'h0000_0000; // hub id after reset
  localparam logic [1:0] STRAP_SETTLE = 2'h2; // edges to fill the sync

  ////////////////////////////////////////////////////////////////////////
  // serial management frame layout
  localparam logic [1:0] FRAME_START = 2'h1; // start code 01
  localparam logic [1:0] OP_READ = 2'h2; // opcode 10
  localparam logic [1:0] OP_WRITE = 2'h1; // opcode 01
  localparam logic [1:0] TA_WRITE = 2'h2; // turnaround 10 on a write
  localparam logic [5:0] PREAMBLE_BITS = 6'h20; // 32 ones
  localparam logic [4:0] HDR_LAST = 5'h0d; // header bit 13 of 0..13
  localparam logic [4:0] WR_LAST = 5'h11; // 2 turnaround + 16 data
  localparam logic [4:0] RD_BITS = 5'h10; // 16 data bits driven
  localparam logic [5:0] FRAME_LAST = 6'h3f; // preamble + 32 frame bits
  localparam logic [5:0] HOST_RD_FIRST = 6'h30; // first data bit index
  localparam logic [5:0] HOST_HDR_END = 6'h2e; // host releases from here

  ////////////////////////////////////////////////////////////////////////
  // t4 phy detection window, in inter-repeater data clocks
  localparam logic [2:0] T4_DV_MIN = 3'h4; // about five clocks, low side
  localparam logic [2:0] T4_DV_MAX = 3'h6; // about five clocks, high side

  ////////////////////////////////////////////////////////////////////////
  // eeprom capture
  localparam logic [5:0] EE_BITS = 6'h20; // two sixteen bit words

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS = 25; // 40 mhz system clock
  localparam int MDC_HALF_NS = 200; // least half period of mdc
  localparam logic [3:0] MDC_HALF_CYC =
    4'((MDC_HALF_NS + CLK_NS - 1) / CLK_NS);

endpackage

/* File: design/mgmt_if.sv */
`timescale 1ns/10ps
// serial management bus between host and repeater
interface mgmt_if;
  logic mdc; // management clock, made by the host
  logic host_mdio_o; // host data toward the line
  logic host_mdio_oe; // host drives the line
  logic dev_mdio_o; // device data toward the line
  logic dev_mdio_oe; // device drives the line
  logic mdio; // resolved line level

  // pulled-up line, any driver may pull it low
  assign mdio = (~host_mdio_oe | host_mdio_o) & (~dev_mdio_oe | dev_mdio_o);

  modport host (output mdc, output host_mdio_o, output host_mdio_oe,
                input mdio);
  modport dev (input mdc, output dev_mdio_o, output dev_mdio_oe,
               input mdio);
endinterface

/* File: design/sync2.sv */
`timescale 1ns/10ps
// two flip-flop synchroniser for pin levels
module sync2 #(
  parameter int WIDTH = 1
) (
  input logic clk_i,
  input logic rst_n_i,
  input logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by the second

  // two stages, nothing taps the first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // sync2

/* File: design/repeater_id_field_host.sv */
`timescale 1ns/10ps
// management host: runs frames on the serial bus for its user
module repeater_id_field_host (
  input logic clk_i,
  input logic rst_n_i,
  mgmt_if.host mgmt,
  input logic target_load_i,
  input logic [4:0] target_id_i,
  input logic cmd_valid_i,
  output logic cmd_ready_o,
  input logic cmd_write_i,
  input logic [4:0] cmd_reg_i,
  input logic [15:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic [15:0] rsp_rdata_o,
  output logic [4:0] target_id_o
);
  logic busy_q; // frame in flight
  logic [3:0] div_q; // mdc half period counter
  logic mdc_q; // mdc level
  logic [5:0] idx_q; // bit index, preamble first
  logic [31:0] frame_q; // frame being sent
  logic wr_q; // frame is a write
  logic o_q; // line data
  logic oe_q; // line enable
  logic [15:0] rd_q; // read data shifter
  logic rsp_q; // answer pulse
  logic [15:0] rdata_q; // answer data
  logic [4:0] target_q; // address the device answers at
  logic mdio_s; // synchronised line
  logic tick; // half period elapsed
  logic rise; // mdc about to rise
  logic fall; // mdc about to fall
  logic [5:0] idx_n; // next bit index
  logic [15:0] wdata_fix; // write data after cleanup
  logic [31:0] frame_d; // frame for a new command

  // bit on the line for a given index
  function automatic logic bit_at(input logic [5:0] i,
                                  input logic [31:0] f);
    bit_at = (i < repeater_id_field_pkg::PREAMBLE_BITS) ? 1'b1 : f[~i[4:0]];
  endfunction

  sync2 #(.WIDTH(1)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(mgmt.mdio),
    .q_o(mdio_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode
  assign tick = busy_q && (div_q == repeater_id_field_pkg::MDC_HALF_CYC - 4'h1);
  assign rise = tick && !mdc_q;
  assign fall = tick && mdc_q;
  assign idx_n = idx_q + 6'h1;
  // reserved bits zero, an all-ones id swapped for the current target id
  assign wdata_fix = (cmd_reg_i != repeater_id_field_pkg::REG_STATUS) ? cmd_wdata_i :
    {cmd_wdata_i[15:5] & ~repeater_id_field_pkg::RESERVED_MASK[15:5], // R14
     (cmd_wdata_i[4:0] == repeater_id_field_pkg::ID_ILLEGAL) ? target_q : // R13
     cmd_wdata_i[4:0]};
  // frame goes to the current device address
  assign frame_d = {repeater_id_field_pkg::FRAME_START,
    cmd_write_i ? repeater_id_field_pkg::OP_WRITE : repeater_id_field_pkg::OP_READ,
    target_q, cmd_reg_i, repeater_id_field_pkg::TA_WRITE, wdata_fix}; // R11
  assign cmd_ready_o = !busy_q;
  assign mgmt.mdc = mdc_q;
  assign mgmt.host_mdio_o = o_q;
  assign mgmt.host_mdio_oe = oe_q;
  assign rsp_valid_o = rsp_q;
  assign rsp_rdata_o = rdata_q;
  assign target_id_o = target_q;

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      div_q <= 4'h0;
      mdc_q <= 1'b0;
      idx_q <= 6'h00;
      frame_q <= 32'h0000_0000;
      wr_q <= 1'b0;
      o_q <= 1'b1;
      oe_q <= 1'b0;
      rd_q <= 16'h0000;
      rsp_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      rsp_q <= 1'b0;
      div_q <= tick ? 4'h0 : (busy_q ? div_q + 4'h1 : 4'h0);
      if (!busy_q && cmd_valid_i) begin
        // start: preamble bit on the line, mdc low
        busy_q <= 1'b1;
        frame_q <= frame_d;
        wr_q <= cmd_write_i;
        idx_q <= 6'h00;
        o_q <= bit_at(6'h00, frame_d);
        oe_q <= 1'b1;
      end else if (rise) begin
        // sample read data on the rising edge
        mdc_q <= 1'b1;
        if (!wr_q && idx_q >= repeater_id_field_pkg::HOST_RD_FIRST) begin
          rd_q <= {rd_q[14:0], mdio_s};
        end
      end else if (fall && idx_q == repeater_id_field_pkg::FRAME_LAST) begin
        // last bit done: release and answer
        mdc_q <= 1'b0;
        busy_q <= 1'b0;
        oe_q <= 1'b0;
        o_q <= 1'b1;
        rsp_q <= 1'b1;
        rdata_q <= wr_q ? 16'h0000 : rd_q;
      end else if (fall) begin
        // next bit after the falling edge
        mdc_q <= 1'b0;
        idx_q <= idx_n;
        o_q <= bit_at(idx_n, frame_q);
        oe_q <= wr_q || (idx_n < repeater_id_field_pkg::HOST_HDR_END);
      end
    end
  end

  // follow the device to its new address
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      target_q <= repeater_id_field_pkg::ID_RST;
    end else if (target_load_i) begin
      target_q <= target_id_i;
    end else if (fall && idx_q == repeater_id_field_pkg::FRAME_LAST && wr_q &&
                 frame_q[22:18] == repeater_id_field_pkg::REG_STATUS) begin
      target_q <= frame_q[4:0]; // R11
    end
  end
endmodule // repeater_id_field_host

/* File: design/repeater_id_field_device.sv */
`timescale 1ns/10ps
// repeater identity and status registers with serial bus slave

////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: t4 flag set: valid near fifth clock, sfd
// R2: t4 flag holds until write or reset
// R3: port field shows current or last receiver
// R4: eeprom done flag after identifier read
// R5: id error on shared id contention
// R6: id error while id is all ones
// R7: id error sticks until software write
// R8: repeater id drives the vector pins
// R9: repeater id is the bus address
// R10: straps latched into id at reset release
// R11: id rewritable; host follows new address
// R12: host never duplicates an id; the host does not check the ids it writes for duplicates
// R13: host never writes the all-ones id; host swaps it for target_q, which may itself be all ones
// R14: reserved bits written zero, read undefined
// R15: first eeprom word held in low register
// R16: eeprom bits stored first bit lowest
// R17: second eeprom word held in high register
// R18: zero write clears flags; set wins
module repeater_id_field_device (
  input logic clk_i,
  input logic rst_n_i,
  mgmt_if.dev mgmt,
  input logic [4:0] repeater_id_straps_i,
  input logic ir_activity_n_i,
  input logic ir_data_valid_n_i,
  input logic ir_data_clock_i,
  input logic sfd_seen_i,
  input logic rx_active_i,
  input logic [3:0] rx_port_i,
  input logic ee_bit_valid_i,
  input logic ee_bit_i,
  input logic eeprom_read_done_i,
  output logic [4:0] ir_vector_out_o,
  output logic t4_detected_flag_o,
  output logic repeater_id_error_o
);
  typedef enum logic [2:0] {
    ST_PRE,
    ST_HDR,
    ST_TA,
    ST_RD,
    ST_WR
  } slave_state_t;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edges
  logic [9:0] pins_raw; // bus, strap and inter-repeater pin inputs
  logic [9:0] pins_s; // synchronised copies
  logic mdc_s; // management clock
  logic mdio_s; // management data
  logic [4:0] straps_s; // id straps
  logic act_n_s; // inter-repeater activity, low active
  logic dv_n_s; // inter-repeater data valid, low active
  logic dclk_s; // inter-repeater data clock
  logic [3:0] prev_q; // last mdc, activity, valid, data clock
  logic mdc_rise; // mdc rising edge
  logic act_fall; // activity asserted
  logic dv_fall; // data valid asserted
  logic dclk_rise; // data clock rising edge

  assign pins_raw = {mgmt.mdc, mgmt.mdio, repeater_id_straps_i,
                     ir_activity_n_i, ir_data_valid_n_i, ir_data_clock_i};

  sync2 #(.WIDTH(10)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  assign mdc_s = pins_s[9];
  assign mdio_s = pins_s[8];
  assign straps_s = pins_s[7:3];
  assign act_n_s = pins_s[2];
  assign dv_n_s = pins_s[1];
  assign dclk_s = pins_s[0];
  assign mdc_rise = mdc_s && !prev_q[3];
  assign act_fall = !act_n_s && prev_q[2];
  assign dv_fall = !dv_n_s && prev_q[1];
  assign dclk_rise = dclk_s && !prev_q[0];

  // previous levels, same as the synchroniser's reset levels
  // so no false activity or valid edge follows reset release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 4'h0;
    end else begin
      prev_q <= {mdc_s, act_n_s, dv_n_s, dclk_s};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [1:0] settle_q; // edges since reset release
  logic [4:0] id_q; // repeater id field
  logic t4_q; // t4 detected flag
  logic rid_err_q; // repeater id error flag
  logic eeprom_read_done_q; // eeprom read finished
  logic [3:0] port_q; // receiving port number
  logic [5:0] ee_cnt_q; // eeprom bits captured
  logic [31:0] hub_q; // both hub identifier words
  logic [2:0] dcnt_q; // data clocks since activity
  logic track_q; // activity window open
  logic armed_q; // valid came in the window

  ////////////////////////////////////////////////////////////////////////
  // serial slave state
  slave_state_t state_q; // frame position
  logic [5:0] ones_q; // preamble ones seen
  logic [4:0] cnt_q; // bits within the phase
  logic [15:0] sh_q; // incoming shifter
  logic [15:0] rd_q; // outgoing shifter
  logic [4:0] reg_q; // addressed register
  logic oe_q; // device drives the line
  logic o_q; // device line level

  ////////////////////////////////////////////////////////////////////////
  // decode
  logic [13:0] hdr_full; // start, op, address, register
  logic hdr_hit; // frame for this device
  logic [15:0] wdata; // completed write word
  logic wr_status; // write strobe to the status word
  logic strap_take; // one cycle after sync fill
  logic contention; // line pulled low while driving a one
  logic t4_set; // t4 detection event
  logic rid_err_set; // id error event
  logic [15:0] status_word; // status word read value
  logic [15:0] rd_word; // read mux
  logic ee_take; // eeprom bit to store

  assign hdr_full = {sh_q[12:0], mdio_s};
  assign hdr_hit = hdr_full[13:12] == repeater_id_field_pkg::FRAME_START &&
                   hdr_full[9:5] == id_q; // R9
  assign wdata = {sh_q[14:0], mdio_s};
  assign wr_status = mdc_rise && state_q == ST_WR &&
                     cnt_q == repeater_id_field_pkg::WR_LAST &&
                     reg_q == repeater_id_field_pkg::REG_STATUS;
  assign strap_take = settle_q == repeater_id_field_pkg::STRAP_SETTLE;
  assign contention = mdc_rise && oe_q && o_q && !mdio_s; // R5
  assign t4_set = armed_q && sfd_seen_i; // R1
  assign rid_err_set = contention ||
                       id_q == repeater_id_field_pkg::ID_ILLEGAL; // R6
  // reserved bits read as zero
  assign status_word = {3'h0, t4_q, port_q, eeprom_read_done_q, 1'b0,
                        rid_err_q, id_q}; // R14
  assign rd_word = (reg_q == repeater_id_field_pkg::REG_STATUS) ? status_word :
                   (reg_q == repeater_id_field_pkg::REG_HUB_LOW) ? hub_q[15:0] :
                   (reg_q == repeater_id_field_pkg::REG_HUB_HIGH) ? hub_q[31:16] :
                   16'h0000;
  assign ee_take = ee_bit_valid_i && ee_cnt_q < repeater_id_field_pkg::EE_BITS;
  assign ir_vector_out_o = id_q; // R8
  assign t4_detected_flag_o = t4_q;
  assign repeater_id_error_o = rid_err_q;
  assign mgmt.dev_mdio_o = o_q;
  assign mgmt.dev_mdio_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // strap capture and id field
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_q <= 2'h0;
      id_q <= repeater_id_field_pkg::ID_RST;
    end else begin
      settle_q <= (settle_q == 2'h3) ? settle_q : settle_q + 2'h1;
      if (strap_take) begin
        id_q <= straps_s; // R10
      end else if (wr_status) begin
        id_q <= wdata[4:0]; // R11
      end
    end
  end

  // sticky flags, a set beats a clearing write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t4_q <= 1'b0;
      rid_err_q <= 1'b0;
      eeprom_read_done_q <= 1'b0;
    end else begin
      t4_q <= t4_set || (t4_q && !(wr_status &&
              !wdata[repeater_id_field_pkg::T4_BIT])); // R2 R18
      rid_err_q <= rid_err_set || (rid_err_q && !(wr_status &&
                   !wdata[repeater_id_field_pkg::RID_ERR_BIT])); // R7 R18
      eeprom_read_done_q <= eeprom_read_done_q || eeprom_read_done_i; // R4
    end
  end

  // port number follows the receiver, holds when idle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_q <= repeater_id_field_pkg::PORT_RST;
    end else if (rx_active_i) begin
      port_q <= rx_port_i; // R3
    end
  end

  // eeprom bits, first bit into bit zero of the low word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ee_cnt_q <= 6'h00;
      hub_q <= repeater_id_field_pkg::HUB_RST;
    end else if (ee_take) begin
      ee_cnt_q <= ee_cnt_q + 6'h01;
      hub_q[ee_cnt_q[4:0]] <= ee_bit_i; // R15 R16 R17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // t4 detection: valid about five data clocks after activity
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dcnt_q <= 3'h0;
      track_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (act_n_s) begin
      // no activity: window closed
      track_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (act_fall) begin
      dcnt_q <= 3'h0;
      track_q <= 1'b1;
      armed_q <= 1'b0;
    end else begin
      if (dclk_rise && dcnt_q != 3'h7) begin
        dcnt_q <= dcnt_q + 3'h1;
      end
      if (track_q && dv_fall) begin
        track_q <= 1'b0;
        armed_q <= dcnt_q >= repeater_id_field_pkg::T4_DV_MIN &&
                   dcnt_q <= repeater_id_field_pkg::T4_DV_MAX; // R1
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial slave, samples on mdc rise, drives after it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_PRE;
      ones_q <= 6'h00;
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      rd_q <= 16'h0000;
      reg_q <= 5'h00;
      oe_q <= 1'b0;
      o_q <= 1'b1;
    end else if (mdc_rise) begin
      sh_q <= {sh_q[14:0], mdio_s};
      cnt_q <= cnt_q + 5'h01;
      case (state_q)
        ST_PRE: begin
          // count ones, a zero after 32 starts the header
          if (mdio_s) begin
            ones_q <= (ones_q == 6'h3f) ? ones_q : ones_q + 6'h01;
          end else if (ones_q >= repeater_id_field_pkg::PREAMBLE_BITS) begin
            state_q <= ST_HDR;
            cnt_q <= 5'h01;
          end else begin
            ones_q <= 6'h00;
          end
        end
        ST_HDR: begin
          // last header bit decides
          if (cnt_q == repeater_id_field_pkg::HDR_LAST) begin
            ones_q <= 6'h00;
            cnt_q <= 5'h00;
            reg_q <= hdr_full[4:0];
            if (hdr_hit && hdr_full[11:10] == repeater_id_field_pkg::OP_READ) begin
              state_q <= ST_TA;
            end else if (hdr_hit &&
                         hdr_full[11:10] == repeater_id_field_pkg::OP_WRITE) begin
              state_q <= ST_WR;
            end else begin
              state_q <= ST_PRE;
            end
          end
        end
        ST_TA: begin
          // drive the turnaround zero
          oe_q <= 1'b1;
          o_q <= 1'b0;
          rd_q <= rd_word;
          cnt_q <= 5'h00;
          state_q <= ST_RD;
        end
        ST_RD: begin
          // sixteen bits, most significant first, then release
          if (cnt_q == repeater_id_field_pkg::RD_BITS) begin
            oe_q <= 1'b0;
            o_q <= 1'b1;
            state_q <= ST_PRE;
          end else begin
            o_q <= rd_q[15];
            rd_q <= {rd_q[14:0], 1'b0};
          end
        end
        ST_WR: begin
          // turnaround and data, only a status word write is stored, by the write strobe
          if (cnt_q == repeater_id_field_pkg::WR_LAST) begin
            state_q <= ST_PRE;
          end
        end
        default: begin
          state_q <= ST_PRE;
          oe_q <= 1'b0;
        end
      endcase
    end
  end
endmodule // repeater_id_field_device

/* File: sim/repeater_id_field_sva.sv */
`timescale 1ns/10ps
// bus and flag checks beside the host to device link
module repeater_id_field_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mdc,
  input wire logic host_mdio_oe,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe,
  input wire logic sfd_seen_i,
  input wire logic [4:0] ir_vector_out_o,
  input wire logic t4_detected_flag_o,
  input wire logic repeater_id_error_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] up_q; // edges since reset release
  ////////////////////////////////////////////////////////////////////////
  // short count so the strap load is allowed to move the id
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h7) begin
      up_q <= up_q + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  AST_T4_SET: assert property (
    $rose(t4_detected_flag_o) |-> $past(sfd_seen_i))
    else $error("t4 flag rose without sfd");
  AST_T4_HOLD: assert property (
    $fell(t4_detected_flag_o) |-> $past(mdc, 2))
    else $error("t4 flag dropped outside a write");
  AST_RIDERR_ONES: assert property (
    ir_vector_out_o == 5'h1f |-> ##[1:2] repeater_id_error_o)
    else $error("all-ones id without error flag");
  AST_RIDERR_HOLD: assert property (
    $fell(repeater_id_error_o) |-> $past(mdc, 2))
    else $error("id error cleared itself");
  AST_ID_CHANGE: assert property ($changed(ir_vector_out_o) |->
    up_q < 3'h5 || $past(mdc, 2))
    else $error("id moved outside strap load or write");
  AST_BIT_ON_HIGH: assert property (
    dev_mdio_oe && $changed(dev_mdio_o) |-> mdc)
    else $error("device data changed with mdc low");
  AST_TA_ZERO: assert property ($rose(dev_mdio_oe) |-> !host_mdio_oe &&
    !dev_mdio_o ##1 (dev_mdio_oe && !dev_mdio_o) [*8])
    else $error("turnaround not a held zero");
  AST_RELEASE: assert property ($rose(dev_mdio_oe) |->
    ##260 dev_mdio_oe ##[1:16] !dev_mdio_oe)
    else $error("read answer length wrong");
  // main scenarios reached
  COV_READ: cover property ($rose(dev_mdio_oe));
  COV_T4: cover property ($rose(t4_detected_flag_o));
  COV_RIDERR: cover property ($fell(repeater_id_error_o));
endmodule // repeater_id_field_sva

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
// host and device joined over the serial bus
module tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] straps = 5'h0c; // strap pins
  logic act_n = 1'b1, dv_n = 1'b1, dclk = 1'b0, sfd = 1'b0;
  logic rx_act = 1'b0, ee_v = 1'b0, ee_b = 1'b0, eeprom_read_done = 1'b0;
  logic [3:0] rx_port = 4'h0;
  logic tload = 1'b0, cv = 1'b0, cw = 1'b0;
  logic [4:0] tid = 5'h00, creg = 5'h00;
  logic [15:0] cwd = 16'h0000, rd;
  logic ready, rsp_v, t4, rid_err;
  logic [15:0] rsp_d;
  logic [4:0] vect, tgt;
  int fails = 0, samples_checked = 0;
  mgmt_if bus ();
  always #12.5 clk_i = ~clk_i;
  repeater_id_field_host i_repeater_id_field_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .mgmt(bus),
    .target_load_i(tload), .target_id_i(tid), .cmd_valid_i(cv),
    .cmd_ready_o(ready), .cmd_write_i(cw), .cmd_reg_i(creg),
    .cmd_wdata_i(cwd), .rsp_valid_o(rsp_v), .rsp_rdata_o(rsp_d),
    .target_id_o(tgt));
  repeater_id_field_device i_repeater_id_field_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mgmt(bus), .repeater_id_straps_i(straps), .ir_activity_n_i(act_n),
    .ir_data_valid_n_i(dv_n), .ir_data_clock_i(dclk), .sfd_seen_i(sfd),
    .rx_active_i(rx_act), .rx_port_i(rx_port), .ee_bit_valid_i(ee_v),
    .ee_bit_i(ee_b), .eeprom_read_done_i(eeprom_read_done),
    .ir_vector_out_o(vect), .t4_detected_flag_o(t4),
    .repeater_id_error_o(rid_err));
  repeater_id_field_sva i_repeater_id_field_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mdc(bus.mdc), .host_mdio_oe(bus.host_mdio_oe),
    .dev_mdio_o(bus.dev_mdio_o), .dev_mdio_oe(bus.dev_mdio_oe),
    .sfd_seen_i(sfd), .ir_vector_out_o(vect), .t4_detected_flag_o(t4),
    .repeater_id_error_o(rid_err));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // expected status word
  function automatic logic [15:0] stat(input logic t, input logic [3:0] p,
      input logic e, input logic r, input logic [4:0] id);
    return {3'h0, t, p, e, 1'b0, r, id};
  endfunction
  // one host frame, answer left in rd
  task automatic frame(input logic w, input logic [4:0] r,
      input logic [15:0] d);
    int k;
    @(posedge clk_i);
    cv <= 1'b1;
    cw <= w;
    creg <= r;
    cwd <= d;
    @(posedge clk_i);
    cv <= 1'b0;
    #1;
    check("busy", {15'h0, ready}, 16'h0000);
    for (k = 0; k < 1200; k++) begin
      @(posedge clk_i);
      #1;
      if (rsp_v === 1'b1) break;
    end
    if (rsp_v !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    rd = rsp_d;
  endtask
  // reset with given straps, then point the host at them
  task automatic do_reset(input logic [4:0] s);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    straps <= s;
    tick(5);
    rst_n_i <= 1'b1;
    tick(6);
    check("vector", {11'h0, vect}, {11'h0, s});
    tload <= 1'b1;
    tid <= s;
    @(posedge clk_i);
    tload <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_port_ee();
    logic [31:0] bits = 32'h5a3c_96e1;
    @(posedge clk_i);
    rx_act <= 1'b1;
    rx_port <= 4'h9;
    tick(2);
    rx_act <= 1'b0;
    rx_port <= 4'h3;
    for (int k = 0; k < 34; k++) begin
      ee_v <= 1'b1;
      ee_b <= bits[k%32];
      tick(1);
      ee_v <= 1'b0;
      eeprom_read_done <= (k == 33);
      tick(3);
    end
    eeprom_read_done <= 1'b0;
    frame(1'b1, repeater_id_field_pkg::REG_HUB_LOW, 16'hffff);
    frame(1'b0, repeater_id_field_pkg::REG_HUB_LOW, 16'h0000);
    check("hub low", rd, bits[15:0]);
    frame(1'b0, repeater_id_field_pkg::REG_HUB_HIGH, 16'h0000);
    check("hub high", rd, bits[31:16]);
    frame(1'b0, repeater_id_field_pkg::REG_STATUS, 16'h0000);
    check("status", rd, stat(1'b0, 4'h9, 1'b1, 1'b0, 5'h0c));
    frame(1'b0, 5'h02, 16'h0000);
    check("unmapped", rd, 16'h0000);
  endtask
  // inter-repeater burst with n data clocks before valid
  task automatic t4_try(input int n, input logic s, input logic exp);
    @(posedge clk_i);
    act_n <= 1'b0;
    tick(3);
    repeat (n) begin
      dclk <= 1'b1;
      tick(2);
      dclk <= 1'b0;
      tick(2);
    end
    dv_n <= 1'b0;
    tick(4);
    sfd <= s;
    @(posedge clk_i);
    sfd <= 1'b0;
    tick(2);
    check("t4 flag", {15'h0, t4}, {15'h0, exp});
    act_n <= 1'b1;
    dv_n <= 1'b1;
    tick(4);
  endtask
  task automatic s_t4();
    t4_try(2, 1'b1, 1'b0);
    t4_try(5, 1'b0, 1'b0);
    t4_try(5, 1'b1, 1'b1);
    t4_try(2, 1'b1, 1'b1);
    frame(1'b1, repeater_id_field_pkg::REG_STATUS, stat(1'b0, 4'h0, 1'b0, 1'b0, 5'h0c));
    check("t4 cleared", {15'h0, t4}, 16'h0000);
  endtask
  task automatic s_new_id();
    frame(1'b1, repeater_id_field_pkg::REG_STATUS, stat(1'b0, 4'h0, 1'b0, 1'b0, 5'h0a));
    check("new vector", {11'h0, vect}, 16'h000a);
    check("host target", {11'h0, tgt}, 16'h000a);
    frame(1'b0, repeater_id_field_pkg::REG_STATUS, 16'h0000);
    check("new addr", rd, stat(1'b0, 4'h9, 1'b1, 1'b0, 5'h0a));
    frame(1'b1, repeater_id_field_pkg::REG_STATUS, stat(1'b0, 4'h0, 1'b0, 1'b0, 5'h1f));
    check("ones refused", {10'h0, rid_err, vect}, 16'h000a);
  endtask
  task automatic s_bad_id();
    do_reset(5'h1f);
    check("id error", {15'h0, rid_err}, 16'h0001);
    frame(1'b1, repeater_id_field_pkg::REG_STATUS, 16'h001f);
    tick(20);
    check("error held", {15'h0, rid_err}, 16'h0001);
    frame(1'b1, repeater_id_field_pkg::REG_STATUS, 16'h0003);
    // old all-ones id still sets the flag in the write cycle
    check("set wins", {10'h0, rid_err, vect}, 16'h0023);
    frame(1'b1, repeater_id_field_pkg::REG_STATUS, 16'h0003);
    check("error cleared", {10'h0, rid_err, vect}, 16'h0003);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(5'h0c);
    s_port_ee();
    s_t4();
    s_new_id();
    s_bad_id();
    report_and_stop();
  end
endmodule // tb_top
